// ### include/mcst_consts.svh
// constants for the control, status and timer register bank
`ifndef MCST_CONSTS_SVH
`define MCST_CONSTS_SVH

// apb byte offsets
`define MCST_OFF_STATUS 8'h00
`define MCST_OFF_BANK 8'h04
`define MCST_OFF_TIMER 8'h08
`define MCST_OFF_IFLAG 8'h0c
`define MCST_OFF_CTRL 8'h10
`define MCST_OFF_DIR5 8'h14
`define MCST_OFF_DIR6 8'h18
`define MCST_OFF_DIR7 8'h1c
`define MCST_OFF_WAKE6 8'h20
`define MCST_OFF_SLPCTL 8'h24
`define MCST_OFF_IMASK 8'h28

// status word fields
`define MCST_ST_PAGE_HI 6
`define MCST_ST_PAGE_LO 5
`define MCST_ST_TOUT 4
`define MCST_ST_PDOWN 3
`define MCST_ST_SW_MASK 8'he7
`define MCST_ST_RESET 8'h18

// interrupt flag and mask fields
`define MCST_IF_EXT 3
`define MCST_IF_TMR 0
`define MCST_IF_USED 8'h09

// timer control word fields
`define MCST_CT_PULLUP_N 7
`define MCST_CT_GIE 6
`define MCST_CT_TSRC 5
`define MCST_CT_TEDGE 4
`define MCST_CT_PSA 3
`define MCST_CT_RESET 8'hbf

// sleep and watchdog control fields
`define MCST_SC_OD 6
`define MCST_SC_WATCHDOG_ENABLE 5
`define MCST_SC_DEEP 4
`define MCST_SC_P7WAKE_N 0
`define MCST_SC_USED 8'h79
`define MCST_SC_RESET 8'h31

// register reset values
`define MCST_ALL_ONES 8'hff
`define MCST_ALL_ZERO 8'h00

// timing
`define MCST_CLK_HZ 20000000
`define MCST_WDT_MS 18
`define MCST_OST_MS 18
`define MCST_CYC_DIV2_LAST 2'h1
`define MCST_CYC_DIV4_LAST 2'h3

`endif

// ### include/mcst_pkg.sv
// types for the control, status and timer register bank
package mcst_pkg;
    typedef enum logic [2:0] {
        MCST_RUN  = 3'b001,
        MCST_DEEP = 3'b010,
        MCST_OST  = 3'b100
    } mcst_sleep_t;
endpackage

// ### core/mcst_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module mcst_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_ff <= '0;
            q_o <= '0;
        end else begin
            meta_ff <= d_i;
            q_o <= meta_ff;
        end
    end
endmodule

// ### core/mcst_tick.sv
// period counter that pulses once every LIMIT cycles
`timescale 1ns/100ps
module mcst_tick #(
    parameter logic [19:0] LIMIT = 20'h00010
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic clr_i,
    output logic tick_o
);
    logic [19:0] cnt_ff;
    wire last = (cnt_ff == LIMIT - 20'h00001);

    assign tick_o = last & ~clr_i;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_ff <= 20'h00000;
        end else if (clr_i || last) begin
            cnt_ff <= 20'h00000;
        end else begin
            cnt_ff <= cnt_ff + 20'h00001;
        end
    end
endmodule

// ### core/mcst_regs.sv
// special-function registers, timer, prescaler, watchdog and deep sleep control
//
// Summary of operation
// - jump, call or pc write loads page bits into pc bits 11 and 12
// - returns keep page bits; page comes from the stacked address
// - time-out flag set by sleep, watchdog clear, power up; cleared by time-out
// - power-down flag set by power on and watchdog clear; cleared by sleep
// - bank pointer: bits 7-6 pick bank, bits 5-0 indirect address
// - external flag on int pin falling edge, timer flag on overflow; sticky
// - software writes only clear interrupt flags; unused bits read zero
// - interrupt flag reads return flags anded with mask
// - control bit 7 low enables port pull-ups
// - control bit 6 shows global interrupt enable
// - control bit 5 picks timer source, bit 4 picks pin edge
// - one prescaler, given to timer (bit 3 = 0) or watchdog (1)
// - ratio field divides by 2^(n+1) for timer, 2^n for watchdog
// - timer write clears prescaler; watchdog clear or sleep clears watchdog path
// - internal source steps once per instruction cycle, fosc/2 or fosc/4
// - direction bit 1 makes pin input, 0 makes it output
// - wake-up enables are active low, per pin on port 6, one shared bit for port 7
// - sleep-control bit 6 enables open drain on port-7 pins 6 and 7
// - watchdog enable bit works only while code option is 0
// - clearing bit 4 enters deep sleep; low wake pin sets it, start-up delay
// - watchdog time-out about 18 ms without prescaler resets the device
// - interrupt requested when flag, mask and global enable all set
// - reset sets control bits except bit 6, and all wake-up bits
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/100ps
`include "mcst_consts.svh"
module mcst_regs #(
    parameter logic [19:0] WDT_CYCLES = 20'(`MCST_WDT_MS * (`MCST_CLK_HZ / 1000)),
    parameter logic [19:0] OST_CYCLES = 20'(`MCST_OST_MS * (`MCST_CLK_HZ / 1000))
) (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_B_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // code options and core events
    input wire logic CLK_DIV4_OPT_I,
    input wire logic WDT_CODE_OPT_I,
    input wire logic SLEEP_INST_I,
    input wire logic WDT_CLR_INST_I,
    input wire logic IRQ_EN_INST_I,
    input wire logic IRQ_DIS_INST_I,
    input wire logic IRQ_RET_INST_I,
    input wire logic IRQ_ENTRY_I,
    input wire logic PC_LOAD_I,
    input wire logic PC_RETURN_I,
    input wire logic [1:0] RET_PAGE_I,
    // core outputs
    output logic [1:0] PC_PAGE_O,
    output logic [1:0] BANK_SEL_O,
    output logic [5:0] IND_ADDR_O,
    output logic IRQ_REQ_O,
    output logic WDT_RESET_O,
    output logic OSC_RUN_O,
    output logic CORE_HOLD_O,
    // pins
    input wire logic INT_N_PIN_I,
    input wire logic TCC_PIN_I,
    input wire logic [7:0] PORT6_PIN_I,
    input wire logic [1:0] PORT7_WAKE_PIN_I,
    // pad controls
    output logic [7:0] PORT5_DIR_O,
    output logic [7:0] PORT6_DIR_O,
    output logic [7:0] PORT7_DIR_O,
    output logic PULLUP_EN_N_O,
    output logic OPEN_DRAIN_EN_O
);
    logic [7:0] status_ff;
    logic [7:0] bank_ff;
    logic [7:0] timer_counter_ff;
    logic [7:0] iflag_ff;
    logic [7:0] ctrl_ff;
    logic gie_ff;
    logic [7:0] wake6_ff;
    logic [7:0] slpctl_ff;
    logic [7:0] imask_ff;
    logic [7:0] psc_ff;
    logic [1:0] cyc_ff;
    logic int_s_d_ff;
    logic tcc_s_d_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic irq_ff;
    logic wdt_rst_ff;
    logic hold_ff;
    logic [1:0] page_ff;
    mcst_pkg::mcst_sleep_t state_ff;
    mcst_pkg::mcst_sleep_t nxt_state;

    logic int_s;
    logic tcc_s;
    logic [7:0] p6_s;
    logic [1:0] p7_s;
    logic wdt_base_tick;
    logic ost_done;

    function automatic logic ratio_hit(input logic [7:0] cnt, input logic [3:0] bits);
        logic [8:0] mask;
        mask = (9'h001 << bits) - 9'h001;
        ratio_hit = (({1'b0, cnt} & mask) == 9'h000);
    endfunction

    // pin synchronisers
    mcst_sync #(.W(12)) u_sync (
        .clk_i(CLK_I),
        .rst_b_i(RST_B_I),
        .d_i({INT_N_PIN_I, TCC_PIN_I, PORT6_PIN_I, PORT7_WAKE_PIN_I}),
        .q_o({int_s, tcc_s, p6_s, p7_s})
    );

    // apb decode
    // read data is captured at setup, so the access cycle answers with no wait state
    wire setup = PSEL_I & ~PENABLE_I;
    wire wr_en = PSEL_I & PENABLE_I & PWRITE_I & pready_ff;
    wire [7:0] wd = PWDATA_I[7:0];
    wire hit_status = (PADDR_I == `MCST_OFF_STATUS);
    wire hit_bank = (PADDR_I == `MCST_OFF_BANK);
    wire hit_timer = (PADDR_I == `MCST_OFF_TIMER);
    wire hit_iflag = (PADDR_I == `MCST_OFF_IFLAG);
    wire hit_ctrl = (PADDR_I == `MCST_OFF_CTRL);
    wire hit_dir5 = (PADDR_I == `MCST_OFF_DIR5);
    wire hit_dir6 = (PADDR_I == `MCST_OFF_DIR6);
    wire hit_dir7 = (PADDR_I == `MCST_OFF_DIR7);
    wire hit_wake6 = (PADDR_I == `MCST_OFF_WAKE6);
    wire hit_slpctl = (PADDR_I == `MCST_OFF_SLPCTL);
    wire hit_imask = (PADDR_I == `MCST_OFF_IMASK);
    wire hit_any = hit_status | hit_bank | hit_timer | hit_iflag | hit_ctrl | hit_dir5
                 | hit_dir6 | hit_dir7 | hit_wake6 | hit_slpctl | hit_imask;

    // read view
    wire [7:0] ctrl_view = {ctrl_ff[7], gie_ff, ctrl_ff[5:0]};
    wire [7:0] iflag_view = iflag_ff & imask_ff & `MCST_IF_USED;
    wire [7:0] rd_byte = hit_status ? status_ff :
                         hit_bank ? bank_ff :
                         hit_timer ? timer_counter_ff :
                         hit_iflag ? iflag_view :
                         hit_ctrl ? ctrl_view :
                         hit_dir5 ? PORT5_DIR_O :
                         hit_dir6 ? PORT6_DIR_O :
                         hit_dir7 ? PORT7_DIR_O :
                         hit_wake6 ? wake6_ff :
                         hit_slpctl ? slpctl_ff :
                         hit_imask ? imask_ff & `MCST_IF_USED : `MCST_ALL_ZERO;

    // instruction cycle divider
    wire [1:0] cyc_last = CLK_DIV4_OPT_I ? `MCST_CYC_DIV4_LAST : `MCST_CYC_DIV2_LAST;
    wire inst_tick = (cyc_ff == cyc_last);

    // timer source and prescaler
    wire tcc_rise = tcc_s & ~tcc_s_d_ff;
    wire tcc_fall = ~tcc_s & tcc_s_d_ff;
    wire pin_evt = ctrl_ff[`MCST_CT_TEDGE] ? tcc_fall : tcc_rise;
    wire src_evt = ctrl_ff[`MCST_CT_TSRC] ? pin_evt : inst_tick;
    wire psa_wdt = ctrl_ff[`MCST_CT_PSA];
    wire [2:0] ratio = ctrl_ff[2:0];
    wire [7:0] psc_inc = psc_ff + 8'h01;
    wire tmr_wr = wr_en & hit_timer;
    wire wdt_clr = SLEEP_INST_I | WDT_CLR_INST_I;
    wire wdt_en = slpctl_ff[`MCST_SC_WATCHDOG_ENABLE] & ~WDT_CODE_OPT_I;
    wire tmr_step = psa_wdt ? src_evt : src_evt & ratio_hit(psc_inc, {1'b0, ratio} + 4'h1);
    wire wdt_out = wdt_en & wdt_base_tick & (~psa_wdt | ratio_hit(psc_inc, {1'b0, ratio}));
    wire psc_clr = psa_wdt ? wdt_clr : tmr_wr;
    wire psc_step = psa_wdt ? wdt_en & wdt_base_tick : src_evt;
    wire tmr_ovf = tmr_step & ~tmr_wr & (timer_counter_ff == `MCST_ALL_ONES);

    // watchdog base period, restarted by clear instructions
    // the base counter runs on the core clock in place of a separate rc oscillator
    mcst_tick #(.LIMIT(WDT_CYCLES)) u_wdt (
        .clk_i(CLK_I),
        .rst_b_i(RST_B_I),
        .clr_i(wdt_clr | ~wdt_en),
        .tick_o(wdt_base_tick)
    );

    // oscillator start-up delay after deep-sleep wake
    mcst_tick #(.LIMIT(OST_CYCLES)) u_ost (
        .clk_i(CLK_I),
        .rst_b_i(RST_B_I),
        .clr_i(state_ff != mcst_pkg::MCST_OST),
        .tick_o(ost_done)
    );

    // wake-up detection
    wire p6_wake = |(~p6_s & ~wake6_ff);
    wire p7_wake = ~slpctl_ff[`MCST_SC_P7WAKE_N] & |(~p7_s);
    wire wake_evt = (state_ff == mcst_pkg::MCST_DEEP) & (p6_wake | p7_wake);

    // sleep state machine
    // the core stays held until the start-up delay has run out
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            mcst_pkg::MCST_RUN: begin
                if (wr_en && hit_slpctl && !wd[`MCST_SC_DEEP]) begin
                    nxt_state = mcst_pkg::MCST_DEEP;
                end
            end
            mcst_pkg::MCST_DEEP: begin
                if (wake_evt) begin
                    nxt_state = mcst_pkg::MCST_OST;
                end
            end
            mcst_pkg::MCST_OST: begin
                if (ost_done) begin
                    nxt_state = mcst_pkg::MCST_RUN;
                end
            end
            default: begin
                nxt_state = mcst_pkg::MCST_RUN;
            end
        endcase
    end

    // next values
    wire [7:0] nxt_status_sw = wr_en & hit_status
                             ? (wd & `MCST_ST_SW_MASK) | (status_ff & ~`MCST_ST_SW_MASK)
                             : status_ff;
    wire nxt_tout = wdt_out ? 1'b0 : (wdt_clr ? 1'b1 : status_ff[`MCST_ST_TOUT]);
    wire nxt_pdown = WDT_CLR_INST_I ? 1'b1
                   : (SLEEP_INST_I ? 1'b0 : status_ff[`MCST_ST_PDOWN]);
    wire [7:0] nxt_status = {nxt_status_sw[7:5], nxt_tout, nxt_pdown, nxt_status_sw[2:0]};
    wire [7:0] iflag_kept = (wr_en & hit_iflag) ? iflag_ff & wd : iflag_ff;
    wire int_fall = ~int_s & int_s_d_ff;
    wire [7:0] iflag_set = {4'h0, int_fall, 2'h0, tmr_ovf};
    wire [7:0] nxt_iflag = (iflag_kept | iflag_set) & `MCST_IF_USED;
    wire nxt_gie = (IRQ_EN_INST_I | IRQ_RET_INST_I) ? 1'b1
                 : ((IRQ_DIS_INST_I | IRQ_ENTRY_I) ? 1'b0 : gie_ff);
    wire [7:0] slp_sw = (wr_en & hit_slpctl) ? wd & `MCST_SC_USED : slpctl_ff;
    wire [7:0] nxt_slpctl = wake_evt ? slp_sw | (8'h01 << `MCST_SC_DEEP) : slp_sw;
    wire [7:0] nxt_timer = tmr_wr ? wd : timer_counter_ff + {7'h00, tmr_step};
    wire nxt_irq = gie_ff & |(iflag_ff & imask_ff & `MCST_IF_USED);
    wire [1:0] nxt_page = PC_RETURN_I ? RET_PAGE_I
                        : (PC_LOAD_I ? status_ff[`MCST_ST_PAGE_HI:`MCST_ST_PAGE_LO] : page_ff);

    // apb response registers
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            prdata_ff <= 32'h00000000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            prdata_ff <= setup ? {24'h000000, rd_byte} : prdata_ff;
            pready_ff <= setup;
            pslverr_ff <= setup & ~hit_any;
        end
    end

    // status, interrupt and page registers
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            status_ff <= `MCST_ST_RESET;
            iflag_ff <= `MCST_ALL_ZERO;
            gie_ff <= 1'b0;
            irq_ff <= 1'b0;
            page_ff <= 2'h0;
        end else begin
            status_ff <= nxt_status;
            iflag_ff <= nxt_iflag;
            gie_ff <= nxt_gie;
            irq_ff <= nxt_irq;
            page_ff <= nxt_page;
        end
    end

    // software-written configuration registers
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            bank_ff <= `MCST_ALL_ZERO;
            ctrl_ff <= `MCST_CT_RESET;
            PORT5_DIR_O <= `MCST_ALL_ONES;
            PORT6_DIR_O <= `MCST_ALL_ONES;
            PORT7_DIR_O <= `MCST_ALL_ONES;
            wake6_ff <= `MCST_ALL_ONES;
            imask_ff <= `MCST_ALL_ZERO;
        end else begin
            bank_ff <= (wr_en & hit_bank) ? wd : bank_ff;
            ctrl_ff <= (wr_en & hit_ctrl) ? wd : ctrl_ff;
            PORT5_DIR_O <= (wr_en & hit_dir5) ? wd : PORT5_DIR_O;
            PORT6_DIR_O <= (wr_en & hit_dir6) ? wd : PORT6_DIR_O;
            PORT7_DIR_O <= (wr_en & hit_dir7) ? wd : PORT7_DIR_O;
            wake6_ff <= (wr_en & hit_wake6) ? wd : wake6_ff;
            imask_ff <= (wr_en & hit_imask) ? wd & `MCST_IF_USED : imask_ff;
        end
    end

    // timer, prescaler, edge history and divider
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            timer_counter_ff <= `MCST_ALL_ZERO;
            psc_ff <= `MCST_ALL_ZERO;
            cyc_ff <= 2'h0;
            // history starts low like the synchroniser, so reset fakes no falling edge
            int_s_d_ff <= 1'b0;
            tcc_s_d_ff <= 1'b0;
        end else begin
            timer_counter_ff <= nxt_timer;
            psc_ff <= psc_clr ? `MCST_ALL_ZERO : (psc_step ? psc_inc : psc_ff);
            cyc_ff <= inst_tick ? 2'h0 : cyc_ff + 2'h1;
            int_s_d_ff <= int_s;
            tcc_s_d_ff <= tcc_s;
        end
    end

    // sleep control, watchdog reset and hold
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            slpctl_ff <= `MCST_SC_RESET;
            state_ff <= mcst_pkg::MCST_RUN;
            wdt_rst_ff <= 1'b0;
            hold_ff <= 1'b0;
        end else begin
            slpctl_ff <= nxt_slpctl;
            state_ff <= nxt_state;
            wdt_rst_ff <= wdt_out;
            hold_ff <= (nxt_state != mcst_pkg::MCST_RUN);
        end
    end

    // outputs
    assign PRDATA_O = prdata_ff;
    assign PREADY_O = pready_ff;
    assign PSLVERR_O = pslverr_ff;
    assign PC_PAGE_O = page_ff;
    assign BANK_SEL_O = bank_ff[7:6];
    assign IND_ADDR_O = bank_ff[5:0];
    assign IRQ_REQ_O = irq_ff;
    assign WDT_RESET_O = wdt_rst_ff;
    assign OSC_RUN_O = slpctl_ff[`MCST_SC_DEEP];
    assign CORE_HOLD_O = hold_ff;
    assign PULLUP_EN_N_O = ctrl_ff[`MCST_CT_PULLUP_N];
    assign OPEN_DRAIN_EN_O = slpctl_ff[`MCST_SC_OD];
endmodule

// ### test/mcst_regs_monitor.sv
// port checker for the register bank, bound to the top module
`timescale 1ns/100ps
`include "mcst_consts.svh"
module mcst_regs_monitor #(
    parameter logic [19:0] WDT_CYCLES = 20'h00010,
    parameter logic [19:0] OST_CYCLES = 20'h00008
) (
    // clock, reset and bus
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    // core events and options
    input wire logic WDT_CODE_OPT_I,
    input wire logic IRQ_EN_INST_I,
    input wire logic IRQ_DIS_INST_I,
    input wire logic IRQ_RET_INST_I,
    input wire logic PC_RETURN_I,
    input wire logic [1:0] RET_PAGE_I,
    // watched outputs
    input wire logic [1:0] PC_PAGE_O,
    input wire logic [1:0] BANK_SEL_O,
    input wire logic [5:0] IND_ADDR_O,
    input wire logic IRQ_REQ_O,
    input wire logic WDT_RESET_O,
    input wire logic OSC_RUN_O,
    input wire logic CORE_HOLD_O,
    input wire logic PULLUP_EN_N_O,
    input wire logic OPEN_DRAIN_EN_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    wire wr_acc = PSEL_I && PENABLE_I && PWRITE_I;

    page_return_a: assert property (PC_RETURN_I |=> PC_PAGE_O == $past(RET_PAGE_I))
        else $error("return page not taken from stack");
    bank_write_a: assert property (wr_acc && PADDR_I == `MCST_OFF_BANK
        |=> {BANK_SEL_O, IND_ADDR_O} == $past(PWDATA_I[7:0])) else $error("bank pointer wrong");
    pullup_write_a: assert property ($changed(PULLUP_EN_N_O)
        |-> $past(wr_acc && PADDR_I == `MCST_OFF_CTRL)) else $error("pull-up moved alone");
    odrain_write_a: assert property ($changed(OPEN_DRAIN_EN_O)
        |-> $past(wr_acc && PADDR_I == `MCST_OFF_SLPCTL)) else $error("open drain moved alone");
    wdt_forced_off_a: assert property (WDT_CODE_OPT_I |-> !WDT_RESET_O)
        else $error("watchdog fired while forced off");
    wdt_pulse_a: assert property (WDT_RESET_O |=> !WDT_RESET_O)
        else $error("watchdog reset longer than one cycle");
    gie_off_a: assert property ((IRQ_DIS_INST_I && !IRQ_EN_INST_I && !IRQ_RET_INST_I)
        ##1 !(IRQ_EN_INST_I || IRQ_RET_INST_I) |=> !IRQ_REQ_O) else $error("request kept");
    wake_hold_a: assert property ($rose(OSC_RUN_O) |-> CORE_HOLD_O [*4])
        else $error("start-up delay too short");
    hold_release_a: assert property ($fell(CORE_HOLD_O) |-> OSC_RUN_O && $past(OSC_RUN_O, 4))
        else $error("core released before oscillator settled");
endmodule

bind mcst_regs mcst_regs_monitor #(.WDT_CYCLES(WDT_CYCLES), .OST_CYCLES(OST_CYCLES))
    mcst_regs_monitor_i (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
    .WDT_CODE_OPT_I(WDT_CODE_OPT_I), .IRQ_EN_INST_I(IRQ_EN_INST_I),
    .IRQ_DIS_INST_I(IRQ_DIS_INST_I), .IRQ_RET_INST_I(IRQ_RET_INST_I),
    .PC_RETURN_I(PC_RETURN_I), .RET_PAGE_I(RET_PAGE_I), .PC_PAGE_O(PC_PAGE_O),
    .BANK_SEL_O(BANK_SEL_O), .IND_ADDR_O(IND_ADDR_O), .IRQ_REQ_O(IRQ_REQ_O),
    .WDT_RESET_O(WDT_RESET_O), .OSC_RUN_O(OSC_RUN_O), .CORE_HOLD_O(CORE_HOLD_O),
    .PULLUP_EN_N_O(PULLUP_EN_N_O), .OPEN_DRAIN_EN_O(OPEN_DRAIN_EN_O));

// ### test/tb.sv
// self-checking bench for the register bank
`timescale 1ns/100ps
module tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, div4 = 1'b0, wopt = 1'b1;
    logic int_n = 1'b1, tpin = 1'b0, pready, perr, err;
    logic [7:0] paddr = 8'h00, ev = 8'h00, p6 = 8'hff, d5, d6, d7;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [1:0] rpage = 2'h1, p7 = 2'h3, page, bank;
    logic [5:0] ind;
    logic irq, wrst, osc, hold, pu_n, od;
    logic [7:0] rstv [11] = '{8'h18, 8'h00, 8'h00, 8'h00, 8'hbf, 8'hff, 8'hff, 8'hff,
        8'hff, 8'h31, 8'h00};
    int n_mismatch = 0, n_compared = 0, k, j, n;

    always #25 clk = ~clk;

    mcst_regs #(.WDT_CYCLES(20'h00010), .OST_CYCLES(20'h00008)) mcst_regs_i (
        .CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(perr), .CLK_DIV4_OPT_I(div4), .WDT_CODE_OPT_I(wopt),
        .SLEEP_INST_I(ev[0]), .WDT_CLR_INST_I(ev[1]), .IRQ_EN_INST_I(ev[2]),
        .IRQ_DIS_INST_I(ev[3]), .IRQ_RET_INST_I(ev[4]), .IRQ_ENTRY_I(ev[5]),
        .PC_LOAD_I(ev[6]), .PC_RETURN_I(ev[7]), .RET_PAGE_I(rpage), .PC_PAGE_O(page),
        .BANK_SEL_O(bank), .IND_ADDR_O(ind), .IRQ_REQ_O(irq), .WDT_RESET_O(wrst),
        .OSC_RUN_O(osc), .CORE_HOLD_O(hold), .INT_N_PIN_I(int_n), .TCC_PIN_I(tpin),
        .PORT6_PIN_I(p6), .PORT7_WAKE_PIN_I(p7), .PORT5_DIR_O(d5), .PORT6_DIR_O(d6),
        .PORT7_DIR_O(d7), .PULLUP_EN_N_O(pu_n), .OPEN_DRAIN_EN_O(od));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer, waits for pready, takes data at that edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int c;
        c = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            c++;
        end while (pready !== 1'b1 && c < 16);
        if (c >= 16) n_mismatch++;
        rd = prdata;
        err = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(rd, {24'h0, e});
    endtask

    task automatic rng(input logic [7:0] a, input int lo, input int hi);
        apb(1'b0, a, 8'h00);
        chk(rd >= lo && rd <= hi, 1'b1);
    endtask

    task automatic pulse(input int i);
        @(posedge clk);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev[i] <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
    endtask

    // counts cycles until a watchdog reset pulse, 300 at most
    task automatic wwait(output int c);
        c = 0;
        while (wrst !== 1'b1 && c < 300) begin
            @(negedge clk);
            c++;
        end
    endtask

    task automatic do_reset;
        @(posedge clk);
        rst_b <= 1'b0;
        cyc(16);
        rst_b <= 1'b1;
    endtask

    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #1000000;
        n_mismatch++;
        end_sim();
    end

    initial begin
        do_reset();
        for (k = 0; k < 11; k++) rc(8'(k * 4), rstv[k]);
        chk({d5, d6, d7, pu_n, od, osc, hold}, 32'h0ffffffa);
        // page bits, returns, time-out and power-down flags
        wr(8'h00, 8'h60);
        rc(8'h00, 8'h78);
        pulse(6);
        chk(page, 2'h3);
        pulse(7);
        chk(page, 2'h1);
        rc(8'h00, 8'h78);
        pulse(0);
        rc(8'h00, 8'h70);
        pulse(1);
        rc(8'h00, 8'h78);
        // bank pointer, directions, unmapped access
        wr(8'h04, 8'ha5);
        wr(8'h14, 8'h5a);
        wr(8'h18, 8'ha5);
        wr(8'h1c, 8'h3c);
        @(negedge clk);
        chk({bank, ind, d5, d6, d7}, 32'ha55aa53c);
        wr(8'h30, 8'h00);
        chk(err, 1'b1);
        apb(1'b0, 8'h2c, 8'h00);
        chk({err, rd[30:0]}, 32'h80000000);
        rc(8'h04, 8'ha5);
        // interrupt flags, mask and global enable
        wr(8'h28, 8'h09);
        int_n <= 1'b0;
        cyc(8);
        int_n <= 1'b1;
        rc(8'h0c, 8'h08);
        wr(8'h0c, 8'hff);
        rc(8'h0c, 8'h08);
        chk(irq, 1'b0);
        pulse(2);
        chk(irq, 1'b1);
        rc(8'h10, 8'hff);
        wr(8'h28, 8'h01);
        rc(8'h0c, 8'h00);
        chk(irq, 1'b0);
        wr(8'h28, 8'h09);
        pulse(5);
        chk(irq, 1'b0);
        rc(8'h10, 8'hbf);
        pulse(4);
        chk(irq, 1'b1);
        pulse(3);
        rc(8'h10, 8'hbf);
        wr(8'h0c, 8'h00);
        rc(8'h0c, 8'h00);
        // timer rates, prescaler and overflow
        wr(8'h10, 8'h08);
        @(negedge clk);
        chk(pu_n, 1'b0);
        wr(8'h08, 8'h00);
        cyc(100);
        rng(8'h08, 46, 54);
        div4 <= 1'b1;
        wr(8'h08, 8'h00);
        cyc(100);
        rng(8'h08, 23, 28);
        div4 <= 1'b0;
        wr(8'h10, 8'h00);
        wr(8'h08, 8'h00);
        cyc(100);
        rng(8'h08, 23, 28);
        wr(8'h10, 8'h07);
        wr(8'h08, 8'h00);
        cyc(100);
        rc(8'h08, 8'h00);
        cyc(356);
        wr(8'h08, 8'h00);
        cyc(100);
        rc(8'h08, 8'h00);
        wr(8'h10, 8'h08);
        wr(8'h08, 8'hf0);
        rc(8'h0c, 8'h00);
        cyc(40);
        rc(8'h0c, 8'h01);
        for (j = 0; j < 2; j++) begin
            wr(8'h10, j ? 8'h38 : 8'h28);
            wr(8'h08, 8'h00);
            for (k = 0; k < 10; k++) begin
                tpin <= ~tpin;
                cyc(4);
            end
            rc(8'h08, 8'h05);
        end
        // deep sleep and wake-up pins
        wr(8'h20, 8'hfe);
        wr(8'h24, 8'h61);
        cyc(2);
        chk({osc, hold, od}, 3'b011);
        p6 <= 8'hfd;
        cyc(10);
        chk(osc, 1'b0);
        p6 <= 8'hfe;
        cyc(6);
        chk({osc, hold}, 2'b11);
        p6 <= 8'hff;
        cyc(12);
        chk(hold, 1'b0);
        rc(8'h24, 8'h71);
        wr(8'h24, 8'h60);
        p7 <= 2'h1;
        cyc(8);
        chk(osc, 1'b1);
        p7 <= 2'h3;
        cyc(12);
        // watchdog period per ratio, time-out flag, enable bit
        wopt <= 1'b0;
        do_reset();
        for (k = 0; k < 3; k++) begin
            wr(8'h10, 8'h88 | 8'(k));
            pulse(1);
            wwait(n);
            chk(n >= (16 << k) - 6 && n <= (16 << k) + 3, 1'b1);
        end
        rc(8'h00, 8'h08);
        wr(8'h24, 8'h11);
        pulse(1);
        wwait(n);
        chk(n == 300, 1'b1);
        end_sim();
    end
endmodule
